// File: shared/cpsl_pkg.sv
// Constants and carrier types for the card power switch serial link.
// Assumes a single 20 MHz system clock standing in for the bus clock.
package cpsl_pkg;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int unsigned CLK_HZ       = 20_000_000;
    localparam int unsigned CLK_DIV      = 36;
    localparam int unsigned SW_MAX_HZ    = 2_000_000;
    localparam int unsigned HALF_DIV     = CLK_DIV / 2;
    localparam logic [5:0]  HALF_LAST    = 6'(HALF_DIV - 1);
    localparam logic [5:0]  CNT_ZERO     = 6'h00;

    // ------------------------------------------------------------
    // Word layout: socket A then socket B, two fields each
    // ------------------------------------------------------------
    localparam int unsigned WORD_BITS    = 8;
    localparam logic [3:0]  BIT_LAST     = 4'(WORD_BITS - 1);
    localparam logic [3:0]  BIT_ZERO     = 4'h0;

    // ------------------------------------------------------------
    // Serial EEPROM loader
    // ------------------------------------------------------------
    localparam int unsigned EE_BITS      = 16;
    localparam logic [4:0]  EE_LAST      = 5'(EE_BITS - 1);
    localparam logic [15:0] EE_WORD_RST  = 16'h0000;

    typedef struct packed {
        logic [1:0] vpp_a;
        logic [1:0] vcc_a;
        logic [1:0] vpp_b;
        logic [1:0] vcc_b;
    } cpsl_pwr_s;

    typedef struct packed {
        logic out;
        logic oe;
    } cpsl_pin_s;

    typedef enum logic [3:0] {
        ST_IDLE  = 4'b0001,
        ST_LOW   = 4'b0010,
        ST_HIGH  = 4'b0100,
        ST_LATCH = 4'b1000
    } cpsl_state_e;

endpackage : cpsl_pkg

// File: design/cpsl_eeprom_load.sv
// Serial EEPROM default loader on the two multipurpose pins.
// Assumes the pins are open drain with external pull-ups.
`timescale 1ns/1ns
`default_nettype none
module cpsl_eeprom_load (
    // Clock and reset
    input  wire logic             clk_sys_i,
    input  wire logic             sys_rst_i,
    // Control
    input  wire logic             enable_i,
    // Pins
    input  wire logic             sda_i,
    output cpsl_pkg::cpsl_pin_s   scl_o,
    output cpsl_pkg::cpsl_pin_s   sda_o,
    // Result
    output logic [15:0]           subsys_id_o,
    output logic                  done_o
);
    logic [5:0]  div_ff;
    logic [4:0]  bit_ff;
    logic        phase_ff;
    logic        done_ff;
    logic [15:0] word_ff;
    wire         tick = (div_ff == cpsl_pkg::HALF_LAST);
    wire         busy = enable_i & ~done_ff;

    // --------------------------------------------------------------
    // Clock the default word in, one bit per slow period
    // --------------------------------------------------------------
    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            div_ff   <= cpsl_pkg::CNT_ZERO;
            bit_ff   <= 5'h00;
            phase_ff <= 1'b0;
            done_ff  <= 1'b0;
            word_ff  <= cpsl_pkg::EE_WORD_RST;
        end else if (busy) begin
            div_ff <= tick ? cpsl_pkg::CNT_ZERO : div_ff + 6'h01;
            if (tick) begin
                phase_ff <= ~phase_ff;
                if (phase_ff) begin
                    word_ff <= {word_ff[14:0], sda_i};
                    bit_ff  <= bit_ff + 5'h01;
                    done_ff <= (bit_ff == cpsl_pkg::EE_LAST);
                end
            end
        end
    end

    // Open drain: drive low only, release for high
    assign scl_o       = '{out: 1'b0, oe: busy & ~phase_ff};
    assign sda_o       = '{out: 1'b0, oe: 1'b0};
    assign subsys_id_o = word_ff;
    assign done_o      = done_ff;
endmodule : cpsl_eeprom_load
`default_nettype wire

// File: design/cpsl_link.sv
// Three-line serial link to an external dual-slot card power switch.
// Assumes the system clock is the bus clock and the latch pin is strapped at reset.
//
// What this block does
// - Data changes at word start and on clock fall, so it is stable at each rising edge.
// - Clock pin is input while the select bit is low; the select bit high turns it into output.
// - Driven clock is the bus clock divided by 36.
// - Switch clock never exceeds 2 MHz when this block drives it; an external clock is not limited.
// - Power-control word leaves one bit at a time on the data line.
// - Latch pulse tells the switch the shifted word is valid.
// - Latch strapped low selects EEPROM clock and data on the multipurpose pins.
// - In EEPROM mode, defaults load over two wires after reset.
`timescale 1ns/1ns
`default_nettype none
module cpsl_link (
    // Clock and reset
    input  wire logic                clk_sys_i,
    input  wire logic                sys_rst_i,
    // Control
    input  wire logic                switch_clock_output_select_i,
    input  wire cpsl_pkg::cpsl_pwr_s pwr_i,
    // Switch pins
    input  wire logic                sw_clk_i,
    output cpsl_pkg::cpsl_pin_s      sw_clk_o,
    output logic                     sw_data_o,
    input  wire logic                sw_latch_i,
    output cpsl_pkg::cpsl_pin_s      sw_latch_o,
    // Multipurpose pins
    input  wire logic                multipurpose_pin_one_i,
    output cpsl_pkg::cpsl_pin_s      multipurpose_pin_one_o,
    output cpsl_pkg::cpsl_pin_s      multipurpose_pin_four_o,
    // Status
    output logic                     eeprom_mode_o,
    output logic [15:0]              subsys_id_o,
    output logic                     eeprom_done_o,
    output logic                     busy_o
);
    // --------------------------------------------------------------
    // Strap capture
    // --------------------------------------------------------------
    logic strap_wait_ff;
    logic eeprom_mode_ff;
    logic nxt_eeprom_mode;

    // Latch pin is released during the first cycle so the strap is readable
    assign nxt_eeprom_mode = strap_wait_ff ? ~sw_latch_i : eeprom_mode_ff;

    // The strap is read once; a later pull on the latch line cannot change mode
    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            strap_wait_ff  <= 1'b1;
            eeprom_mode_ff <= 1'b0;
        end else begin
            strap_wait_ff  <= 1'b0;
            eeprom_mode_ff <= nxt_eeprom_mode;
        end
    end

    // --------------------------------------------------------------
    // Word sender
    // --------------------------------------------------------------
    cpsl_pkg::cpsl_state_e state_ff;
    cpsl_pkg::cpsl_state_e nxt_state;
    cpsl_pkg::cpsl_pwr_s   sent_ff;
    cpsl_pkg::cpsl_pwr_s   nxt_sent;
    logic [7:0]            shift_ff;
    logic [7:0]            nxt_shift;
    logic [5:0]            div_ff;
    logic [5:0]            nxt_div;
    logic [3:0]            bit_ff;
    logic [3:0]            nxt_bit;
    logic                  clk_out_ff;
    logic                  nxt_clk_out;
    logic                  latch_ff;
    logic                  nxt_latch;
    logic                  data_ff;
    logic                  nxt_data;
    logic                  ext_clk_ff;

    // One decode shared by the event and status logic
    function automatic logic in_state(input cpsl_pkg::cpsl_state_e cur, input cpsl_pkg::cpsl_state_e want);
        in_state = (cur == want);
    endfunction : in_state

    // Shift a byte left by one, filling with zero
    function automatic logic [7:0] shl1(input logic [7:0] v);
        shl1 = {v[6:0], 1'b0};
    endfunction : shl1

    // --------------------------------------------------------------
    // Events
    // --------------------------------------------------------------
    wire st_idle   = in_state(state_ff, cpsl_pkg::ST_IDLE);
    wire st_low    = in_state(state_ff, cpsl_pkg::ST_LOW);
    wire st_high   = in_state(state_ff, cpsl_pkg::ST_HIGH);
    wire half_done = (div_ff == cpsl_pkg::HALF_LAST);
    wire changed   = (pwr_i != sent_ff) & ~strap_wait_ff;
    wire use_int   = switch_clock_output_select_i;
    wire ext_rise  = sw_clk_i & ~ext_clk_ff;
    wire ext_fall  = ~sw_clk_i & ext_clk_ff;
    wire rise_evt  = st_low & (use_int ? half_done : ext_rise);
    wire fall_evt  = st_high & (use_int ? half_done : ext_fall);
    wire last_bit  = (bit_ff == cpsl_pkg::BIT_LAST);
    wire start     = st_idle & changed;
    wire advance   = fall_evt & ~last_bit;

    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            cpsl_pkg::ST_IDLE:  if (changed) nxt_state = cpsl_pkg::ST_LOW;
            cpsl_pkg::ST_LOW:   if (rise_evt) nxt_state = cpsl_pkg::ST_HIGH;
            cpsl_pkg::ST_HIGH:  if (fall_evt) nxt_state = last_bit ? cpsl_pkg::ST_LATCH : cpsl_pkg::ST_LOW;
            cpsl_pkg::ST_LATCH: if (half_done) nxt_state = cpsl_pkg::ST_IDLE;
            default:            nxt_state = cpsl_pkg::ST_IDLE;
        endcase
    end

    // --------------------------------------------------------------
    // Next values
    // --------------------------------------------------------------
    // Half period of 18 cycles gives 20 MHz / 36, well under 2 MHz
    // Restarting on every fall keeps the latch at 18 cycles with an external clock too
    assign nxt_div     = (half_done | fall_evt | st_idle) ? cpsl_pkg::CNT_ZERO : div_ff + 6'h01;
    assign nxt_sent    = start ? pwr_i : sent_ff;
    assign nxt_shift   = start ? shl1(pwr_i) : advance ? shl1(shift_ff) : shift_ff;
    assign nxt_data    = start ? pwr_i[7] : advance ? shift_ff[7] : data_ff;
    assign nxt_bit     = start ? cpsl_pkg::BIT_ZERO : advance ? bit_ff + 4'h1 : bit_ff;
    assign nxt_clk_out = rise_evt | (clk_out_ff & ~fall_evt);
    assign nxt_latch   = (nxt_state == cpsl_pkg::ST_LATCH);

    // --------------------------------------------------------------
    // Sequencer registers
    // --------------------------------------------------------------
    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            state_ff <= cpsl_pkg::ST_IDLE;
            div_ff   <= cpsl_pkg::CNT_ZERO;
            bit_ff   <= cpsl_pkg::BIT_ZERO;
        end else begin
            state_ff <= nxt_state;
            div_ff   <= nxt_div;
            bit_ff   <= nxt_bit;
        end
    end

    // --------------------------------------------------------------
    // Word registers
    // --------------------------------------------------------------
    // The sent copy is taken at the start, so a change during a send waits for idle
    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            sent_ff  <= '0;
            shift_ff <= 8'h00;
        end else begin
            sent_ff  <= nxt_sent;
            shift_ff <= nxt_shift;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            data_ff <= 1'b0;
        end else begin
            data_ff <= nxt_data;
        end
    end

    // --------------------------------------------------------------
    // Pin registers
    // --------------------------------------------------------------
    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            clk_out_ff <= 1'b0;
            latch_ff   <= 1'b0;
        end else begin
            clk_out_ff <= nxt_clk_out;
            latch_ff   <= nxt_latch;
        end
    end

    // External clock is taken as synchronous; one stage gives its edges
    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            ext_clk_ff <= 1'b0;
        end else begin
            ext_clk_ff <= sw_clk_i;
        end
    end

    // --------------------------------------------------------------
    // EEPROM loader on the multipurpose pins
    // --------------------------------------------------------------
    cpsl_eeprom_load u_ee (
        .clk_sys_i   (clk_sys_i),
        .sys_rst_i   (sys_rst_i),
        .enable_i    (eeprom_mode_ff & ~strap_wait_ff),
        .sda_i       (multipurpose_pin_one_i),
        .scl_o       (multipurpose_pin_four_o),
        .sda_o       (multipurpose_pin_one_o),
        .subsys_id_o (subsys_id_o),
        .done_o      (eeprom_done_o)
    );

    // --------------------------------------------------------------
    // Pins
    // --------------------------------------------------------------
    assign sw_clk_o      = '{out: clk_out_ff, oe: use_int};
    assign sw_latch_o    = '{out: latch_ff, oe: ~strap_wait_ff};
    assign sw_data_o     = data_ff;
    assign eeprom_mode_o = eeprom_mode_ff;
    assign busy_o        = ~st_idle;
endmodule : cpsl_link
`default_nettype wire

// File: dv/cpsl_link_assertions.sv
// Port assertions for the switch link.
// Assumes binding into cpsl_link.
`timescale 1ns/1ns
`default_nettype none
module cpsl_link_assertions (
    // Clock, reset, control
    input wire logic                clk_sys_i,
    input wire logic                sys_rst_i,
    input wire logic                switch_clock_output_select_i,
    input wire cpsl_pkg::cpsl_pwr_s pwr_i,
    input wire logic                sw_latch_i,
    // Observed outputs
    input wire cpsl_pkg::cpsl_pin_s sw_clk_o,
    input wire logic                sw_data_o,
    input wire cpsl_pkg::cpsl_pin_s sw_latch_o,
    input wire cpsl_pkg::cpsl_pin_s multipurpose_pin_four_o,
    input wire logic                eeprom_mode_o,
    input wire logic                eeprom_done_o,
    input wire logic                busy_o
);
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (sys_rst_i);
    chk_clk_oe_sel: assert property (sw_clk_o.oe == switch_clock_output_select_i)
        else $error("clock enable differs from select");
    chk_clk_high_len: assert property (switch_clock_output_select_i && $rose(sw_clk_o.out) |-> ##18 $fell(sw_clk_o.out))
        else $error("clock high phase not 18 cycles");
    chk_data_hold: assert property ($changed(sw_data_o) |-> !sw_clk_o.out)
        else $error("data moved while clock high");
    chk_latch_len: assert property ($rose(sw_latch_o.out) |-> ##18 $fell(sw_latch_o.out))
        else $error("latch pulse not 18 cycles");
    chk_latch_clk_low: assert property (sw_latch_o.out |-> !sw_clk_o.out)
        else $error("clock high during latch");
    chk_send_start: assert property (!busy_o && $changed(pwr_i) && !$past(sys_rst_i) |=> busy_o)
        else $error("setting change not taken");
    chk_mode_strap: assert property ($past(sys_rst_i) && !sys_rst_i |=> eeprom_mode_o == !$past(sw_latch_i))
        else $error("strap not sampled");
    chk_scl_unused: assert property (!eeprom_mode_o |-> !multipurpose_pin_four_o.oe)
        else $error("eeprom clock driven outside mode");
    chk_clk_idle_low: assert property (!busy_o |-> !sw_clk_o.out)
        else $error("clock not low while idle");
    cov_latch: cover property ($rose(sw_latch_o.out));
    cov_ext_latch: cover property (!switch_clock_output_select_i && $rose(sw_latch_o.out));
    cov_clk: cover property ($rose(sw_clk_o.out));
    cov_done: cover property ($rose(eeprom_done_o));
endmodule : cpsl_link_assertions
bind cpsl_link cpsl_link_assertions u_chk (.clk_sys_i, .sys_rst_i, .switch_clock_output_select_i, .pwr_i,
    .sw_latch_i, .sw_clk_o, .sw_data_o, .sw_latch_o, .multipurpose_pin_four_o, .eeprom_mode_o,
    .eeprom_done_o, .busy_o);
`default_nettype wire

// File: dv/cpsl_switch_model.sv
// Behavioural power switch on the three-line link.
// Assumes clock and latch wires are resolved by the bench.
`timescale 1ns/1ns
`default_nettype none
module cpsl_switch_model (
    // Link pins
    input wire logic  sclk_i,
    input wire logic  data_i,
    input wire logic  latch_i,
    // Applied setting
    output logic [7:0] word_o,
    output int        n_latch_o,
    output int        n_bits_o
);
    logic [7:0] shift_ff;
    int         bits_ff;
    initial begin
        shift_ff = 8'h00;
        bits_ff = 0;
        word_o = 8'h00;
        n_latch_o = 0;
        n_bits_o = 0;
    end
    // Sampled on the rising edge only, as the real switch does
    always @(posedge sclk_i) begin
        shift_ff <= {shift_ff[6:0], data_i};
        bits_ff <= bits_ff + 1;
    end
    always @(posedge latch_i) begin
        word_o <= shift_ff;
        n_bits_o <= bits_ff;
        n_latch_o <= n_latch_o + 1;
    end
endmodule : cpsl_switch_model
`default_nettype wire

// File: dv/cpsl_link_bench.sv
// Self-checking bench for the switch link.
// Assumes a pull-down on the clock and a pull-up on the EEPROM data pin.
`timescale 1ns/1ns
`default_nettype none
module cpsl_link_bench;
    logic                clk_sys_i, sys_rst_i, sel, strap, data, mode, done, busy, ext_clk;
    cpsl_pkg::cpsl_pwr_s pwr;
    cpsl_pkg::cpsl_pin_s clk_o, lat_o, mp1_o, mp4_o;
    logic [15:0]         sid;
    logic [7:0]          word, w;
    int                  n_latch, n_bits, last_bits, failures, n_checks, i, k;
    int                  exp_q[$];
    wire logic           sclk_w = clk_o.oe ? clk_o.out : ext_clk;
    wire logic           latch_w = lat_o.oe ? lat_o.out : strap;
    wire logic           mp1_w = mp1_o.oe ? mp1_o.out : 1'b1;
    cpsl_link dut (.clk_sys_i, .sys_rst_i, .switch_clock_output_select_i(sel), .pwr_i(pwr), .sw_clk_i(sclk_w),
        .sw_clk_o(clk_o), .sw_data_o(data), .sw_latch_i(latch_w), .sw_latch_o(lat_o), .multipurpose_pin_one_i(mp1_w),
        .multipurpose_pin_one_o(mp1_o), .multipurpose_pin_four_o(mp4_o), .eeprom_mode_o(mode), .subsys_id_o(sid),
        .eeprom_done_o(done), .busy_o(busy));
    cpsl_switch_model u_sw (.sclk_i(sclk_w), .data_i(data), .latch_i(latch_w), .word_o(word), .n_latch_o(n_latch),
        .n_bits_o(n_bits));
    initial begin
        clk_sys_i = 1'b0;
        forever #25 clk_sys_i = ~clk_sys_i;
    end
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            failures++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic summarize();
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : summarize
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys_i);
        #5;
    endtask : tick
    task automatic do_reset(input logic s);
        strap = s;
        sys_rst_i = 1'b1;
        tick(8);
        sys_rst_i = 1'b0;
        tick(2);
    endtask : do_reset
    // Pops the expected queue at every applied word
    task automatic wait_latch();
        int n0;
        n0 = n_latch;
        for (k = 0; k < 2000 && n_latch == n0; k++) @(posedge clk_sys_i);
        #5;
        if (n_latch == n0) begin
            failures++;
            summarize();
        end
        chk(16'(word), 16'(exp_q.pop_front()));
        chk(16'(n_bits - last_bits), 16'h0008);
        last_bits = n_bits;
    endtask : wait_latch
    task automatic send(input logic [7:0] v);
        pwr = v;
        exp_q.push_back(v);
    endtask : send
    initial begin
        {sys_rst_i, sel, strap, ext_clk, pwr, failures, n_checks, last_bits} = '0;
        void'($urandom(32'h1e90));
        sel = 1'b1;
        do_reset(1'b1);
        chk(16'(mode), 16'h0000);
        chk(16'(clk_o.oe), 16'h0001);
        // Next word is set during the latch phase, so it waits for idle
        for (i = 0; i < 6; i++) begin
            w = (i == 0) ? 8'hFF : (i == 5) ? 8'h00 : 8'($urandom);
            if (w == pwr) w = ~w;
            send(w);
            wait_latch();
        end
        send(8'hA5);
        tick(100);
        send(8'h3C);
        wait_latch();
        wait_latch();
        tick(30);
        sel = 1'b0;
        tick(1);
        chk(16'(clk_o.oe), 16'h0000);
        // External clock: the bench plays the far side's clock source
        w = 8'($urandom);
        if (w == pwr) w = ~w;
        send(w);
        for (i = 0; i < 16; i++) begin
            tick(10);
            ext_clk = ~ext_clk;
        end
        wait_latch();
        sel = 1'b1;
        do_reset(1'b0);
        chk(16'(mode), 16'h0001);
        for (k = 0; k < 20000 && done !== 1'b1; k++) tick(1);
        chk(16'(done), 16'h0001);
        chk(sid, 16'hFFFF);
        summarize();
    end
endmodule : cpsl_link_bench
`default_nettype wire
